// ### core/rtmc_handler.sv
/*
  Mode code handler of a remote terminal for codes 07 to 11 (hex):
  override inhibit terminal flag, reset terminal, reserved codes, transmit
  vector word and synchronize with data word. Owns the status bits, the
  subsystem strobes, the highway during sync delivery and a register port.
  Assumes a word decoder on the same clock presents each validated command,
  each following data word and the end of the message as one-cycle pulses,
  and that the transmitter starts the status word on status_req.
*/
// Functional notes
// [RL1] override command: status, then terminal flag re-enabled
// [RL2] inhibited terminal flag stays clear until released
// [RL3] broadcast: no status, set broadcast bit
// [RL4] extra word after no-data code: error, end
// [RL5] codes 07-10 with receive bit: error, no status
// [RL6] reset command: status, then reset low 500 ns
// [RL7] terminal reset clears shutdown and flag inhibit; the code clears only tf_inhibit and has no shutdown state
// [RL8] reserved codes: old status plus message error
// [RL9] vector command: status starts before vector fetch
// [RL10] fetch strobe, latch highway word, send after status
// [RL11] broadcast vector command: error, broadcast, end
// [RL12] sync word held; status after message validated
// [RL13] sync strobe 500 ns with word on highway
// [RL14] sync with extra data words: error, end
// [RL15] sync with transmit bit: error, no status
// [RL16] invalid command ignored; missing sync word errors
`timescale 1ns/1ps
`default_nettype none
`include "rtmc_map.svh"

module rtmc_handler #(
  parameter int unsigned STROBE_CYC = `RTMC_CYC(`RTMC_STROBE_NS),
  parameter int unsigned FETCH_CYC = `RTMC_CYC(`RTMC_FETCH_NS)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ok,
  input wire logic cmd_bcast,
  input wire logic cmd_tr,
  input wire logic [4:0] cmd_mode_code,
  input wire logic word_valid,
  input wire logic word_contig,
  input wire logic [15:0] word_data,
  input wire logic msg_end,
  input wire logic tf_inhibit_set,
  input wire logic tf_request_pin,
  output logic status_req,
  output logic [2:0] status_flags,
  output logic term_reset,
  output logic [15:0] tx_word,
  output logic tx_word_valid,
  input wire logic subsystem_reset_n_in,
  output logic subsystem_reset_n_out,
  output logic subsystem_reset_n_oe_n,
  input wire logic [15:0] subsystem_highway_in,
  output logic [15:0] subsystem_highway_out,
  output logic subsystem_highway_oe_n,
  output logic vector_word_fetch_n,
  output logic sync_word_strobe_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  if (STROBE_CYC < 1 || FETCH_CYC < 3) begin : g_bad_timing
    $error("rtmc_handler: strobe counts too short");
  end

  // a mode code is one of the reserved group
  function automatic logic is_reserved(input logic [4:0] mc);
    is_reserved = (mc >= `RTMC_MC_RSV_LO) && (mc <= `RTMC_MC_RSV_HI);
  endfunction

  // a mode code belongs to this handler
  function automatic logic in_group(input logic [4:0] mc);
    in_group = (mc >= `RTMC_MC_OVR_TF) && (mc <= `RTMC_MC_SYNC);
  endfunction

  rtmc_pkg::rtmc_state_t state; // sequence state
  rtmc_pkg::rtmc_state_t next_state;
  logic [4:0] code; // mode code of the running command
  logic [4:0] next_code;
  logic bcast; // running command is broadcast
  logic next_bcast;
  logic have_word; // sync data word received
  logic next_have_word;
  logic [15:0] sync_word; // buffered sync data word
  logic [15:0] next_sync_word;
  logic stat_me; // message error status bit
  logic next_stat_me;
  logic stat_bcst; // broadcast received status bit
  logic next_stat_bcst;
  logic stat_tf; // terminal flag status bit
  logic next_stat_tf;
  logic tf_inhibit; // terminal flag setting blocked
  logic next_tf_inhibit;
  logic next_status_req;
  logic seq_err; // sequence ended in error, one cycle
  logic next_seq_err;
  logic ovr_pend; // release inhibit after status
  logic next_ovr_pend;
  logic next_term_reset;
  logic rst_go; // start reset strobe
  logic next_rst_go;
  logic vec_go; // start vector fetch
  logic next_vec_go;
  logic sync_go; // start sync delivery
  logic next_sync_go;
  logic [15:0] next_tx_word;
  logic next_tx_word_valid;
  logic tr_bad; // transmit/receive bit wrong for the code

  // pin levels after two stages
  logic [15:0] hw_s; // highway
  logic tf_req_s; // subsystem terminal flag request
  logic ext_rst_s; // reset line level

  rtmc_sync #(.W(18)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({subsystem_reset_n_in, tf_request_pin, subsystem_highway_in}),
    .q({ext_rst_s, tf_req_s, hw_s})
  );

  rtmc_pulse_if rst_if ();
  rtmc_pulse_if vec_if ();
  rtmc_pulse_if syn_if ();

  rtmc_pulse #(.CYCLES(STROBE_CYC)) u_rst_pulse (
    .clk(clk), .rst_n(rst_n), .p(rst_if.gen));
  rtmc_pulse #(.CYCLES(FETCH_CYC)) u_vec_pulse (
    .clk(clk), .rst_n(rst_n), .p(vec_if.gen));
  rtmc_pulse #(.CYCLES(STROBE_CYC)) u_syn_pulse (
    .clk(clk), .rst_n(rst_n), .p(syn_if.gen));

  assign rst_if.start = rst_go;
  assign vec_if.start = vec_go;
  assign syn_if.start = sync_go;

  // register file state
  logic ctrl_tf_sw; // software terminal flag request
  logic next_ctrl_tf_sw;
  logic [`RTMC_EV_W-1:0] evt; // sticky events
  logic [`RTMC_EV_W-1:0] next_evt;
  logic [`RTMC_EV_W-1:0] evt_en; // interrupt enables
  logic [`RTMC_EV_W-1:0] next_evt_en;
  logic [31:0] next_reg_rdata;
  logic [`RTMC_EV_W-1:0] ev_raw; // this cycle's events

  // command sequencing and status bits
  always_comb begin
    next_state = state;
    next_code = code;
    next_bcast = bcast;
    next_have_word = have_word;
    next_sync_word = sync_word;
    next_stat_me = stat_me;
    next_stat_bcst = stat_bcst;
    next_status_req = 1'b0;
    next_seq_err = 1'b0;
    next_ovr_pend = 1'b0; // one-cycle release request
    next_rst_go = 1'b0;
    next_vec_go = 1'b0;
    next_sync_go = 1'b0;
    tr_bad = (cmd_mode_code == `RTMC_MC_SYNC) ? cmd_tr : !cmd_tr;
    unique case (state)
      rtmc_pkg::ST_IDLE: begin
        next_state = rtmc_pkg::ST_IDLE;
      end
      rtmc_pkg::ST_WAIT_END: begin
        if (word_valid) begin
          // no-data code followed by a word
          next_stat_me = 1'b1; // RL4
          next_seq_err = 1'b1;
          next_state = rtmc_pkg::ST_IDLE;
        end else if (msg_end) begin
          next_state = rtmc_pkg::ST_IDLE;
          if (is_reserved(code)) begin
            // old status kept, error added
            next_stat_me = 1'b1; // RL8
            next_stat_bcst = stat_bcst | bcast;
            next_status_req = !bcast;
          end else if (code == `RTMC_MC_VECTOR && bcast) begin
            next_stat_me = 1'b1; // RL11
            next_stat_bcst = 1'b1;
            next_seq_err = 1'b1;
          end else begin
            // silent on broadcast, answer otherwise
            next_stat_bcst = bcast; // RL3
            next_status_req = !bcast;
            next_vec_go = (code == `RTMC_MC_VECTOR); // RL9
            next_rst_go = (code == `RTMC_MC_RESET); // RL6
            next_ovr_pend = (code == `RTMC_MC_OVR_TF); // RL1
          end
        end
      end
      rtmc_pkg::ST_WAIT_DATA: begin
        if (word_valid) begin
          if (have_word || !word_contig) begin
            next_stat_me = 1'b1; // RL14
            next_seq_err = 1'b1;
            next_state = rtmc_pkg::ST_IDLE;
          end else begin
            next_sync_word = word_data; // RL12
            next_have_word = 1'b1;
          end
        end else if (msg_end) begin
          next_state = rtmc_pkg::ST_IDLE;
          if (!have_word) begin
            next_stat_me = 1'b1; // RL16
            next_seq_err = 1'b1;
          end else begin
            // validated: answer, then deliver
            next_stat_bcst = bcast; // RL3
            next_status_req = !bcast; // RL12
            next_sync_go = 1'b1;
          end
        end
      end
      default: next_state = rtmc_pkg::ST_IDLE;
    endcase
    // a new valid command restarts; invalid ones never reach here
    if (cmd_valid && cmd_ok && in_group(cmd_mode_code)) begin // RL16
      next_code = cmd_mode_code;
      next_bcast = cmd_bcast;
      next_have_word = 1'b0;
      if (tr_bad) begin
        next_stat_me = 1'b1; // RL5 RL15
        next_stat_bcst = cmd_bcast;
        next_seq_err = 1'b1;
        next_state = rtmc_pkg::ST_IDLE;
      end else begin
        if (!is_reserved(cmd_mode_code)) begin
          next_stat_me = 1'b0;
          next_stat_bcst = 1'b0;
        end
        next_state = (cmd_mode_code == `RTMC_MC_SYNC) ?
          rtmc_pkg::ST_WAIT_DATA : rtmc_pkg::ST_WAIT_END;
      end
    end
  end

  // terminal flag, inhibit and vector latch
  always_comb begin
    next_tf_inhibit = tf_inhibit;
    if (tf_inhibit_set) begin
      next_tf_inhibit = 1'b1;
    end
    if (ovr_pend || rst_go) begin
      next_tf_inhibit = 1'b0; // RL1 RL7
    end
    next_term_reset = rst_go; // RL7
    next_stat_tf = (tf_req_s | ctrl_tf_sw) & !tf_inhibit; // RL2
    next_tx_word = tx_word;
    next_tx_word_valid = 1'b0;
    if (vec_if.done) begin
      next_tx_word = hw_s; // RL10
      next_tx_word_valid = 1'b1;
    end
  end

  // register sequencing state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rtmc_pkg::ST_IDLE;
      code <= 5'h00;
      bcast <= 1'b0;
      have_word <= 1'b0;
      sync_word <= 16'h0000;
      stat_me <= 1'b0;
      stat_bcst <= 1'b0;
      stat_tf <= 1'b0;
      tf_inhibit <= 1'b0;
      status_req <= 1'b0;
      seq_err <= 1'b0;
      ovr_pend <= 1'b0;
      term_reset <= 1'b0;
      rst_go <= 1'b0;
      vec_go <= 1'b0;
      sync_go <= 1'b0;
      tx_word <= 16'h0000;
      tx_word_valid <= 1'b0;
    end else begin
      state <= next_state;
      code <= next_code;
      bcast <= next_bcast;
      have_word <= next_have_word;
      sync_word <= next_sync_word;
      stat_me <= next_stat_me;
      stat_bcst <= next_stat_bcst;
      stat_tf <= next_stat_tf;
      tf_inhibit <= next_tf_inhibit;
      status_req <= next_status_req;
      seq_err <= next_seq_err;
      ovr_pend <= next_ovr_pend;
      term_reset <= next_term_reset;
      rst_go <= next_rst_go;
      vec_go <= next_vec_go;
      sync_go <= next_sync_go;
      tx_word <= next_tx_word;
      tx_word_valid <= next_tx_word_valid;
    end
  end

  // subsystem pins: reset is open drain, highway driven during sync
  assign subsystem_reset_n_out = 1'b0;
  assign subsystem_reset_n_oe_n = !rst_if.active; // RL6
  assign subsystem_highway_out = sync_word; // RL13
  assign subsystem_highway_oe_n = !syn_if.active;
  assign sync_word_strobe_n = !syn_if.active; // RL13
  assign vector_word_fetch_n = !vec_if.active; // RL10
  assign status_flags = {stat_tf, stat_bcst, stat_me};

  // events: set wins over a clear in the same cycle
  always_comb begin
    ev_raw = '0;
    ev_raw[`RTMC_EV_STATUS] = status_req;
    ev_raw[`RTMC_EV_MERR] = seq_err;
    ev_raw[`RTMC_EV_RESET] = rst_if.done;
    ev_raw[`RTMC_EV_SYNC] = syn_if.done;
    ev_raw[`RTMC_EV_VECTOR] = tx_word_valid;
    next_evt = evt | ev_raw;
    next_evt_en = evt_en;
    next_ctrl_tf_sw = ctrl_tf_sw;
    if (reg_wr) begin
      unique case (reg_addr)
        `RTMC_OFF_CTRL: next_ctrl_tf_sw = reg_wdata[`RTMC_CTRL_TF_SW];
        `RTMC_OFF_EVT_CLR:
          next_evt = (evt & ~reg_wdata[`RTMC_EV_W-1:0]) | ev_raw;
        `RTMC_OFF_EVT_EN: next_evt_en = reg_wdata[`RTMC_EV_W-1:0];
        default: next_evt = evt | ev_raw;
      endcase
    end
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `RTMC_OFF_STAT: begin
          next_reg_rdata[`RTMC_ST_ME] = stat_me;
          next_reg_rdata[`RTMC_ST_BCST] = stat_bcst;
          next_reg_rdata[`RTMC_ST_TF] = stat_tf;
          next_reg_rdata[`RTMC_ST_INH] = tf_inhibit;
          next_reg_rdata[`RTMC_ST_EXT_RST] = !ext_rst_s;
        end
        `RTMC_OFF_CTRL: next_reg_rdata[`RTMC_CTRL_TF_SW] = ctrl_tf_sw;
        `RTMC_OFF_EVT: next_reg_rdata[`RTMC_EV_W-1:0] = evt;
        `RTMC_OFF_EVT_EN: next_reg_rdata[`RTMC_EV_W-1:0] = evt_en;
        `RTMC_OFF_VECTOR: next_reg_rdata[15:0] = tx_word;
        `RTMC_OFF_SYNC: next_reg_rdata[15:0] = sync_word;
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
      evt_en <= `RTMC_RST_EVT_EN;
      ctrl_tf_sw <= `RTMC_RST_CTRL;
      reg_rdata <= 32'h0000_0000;
    end else begin
      evt <= next_evt;
      evt_en <= next_evt_en;
      ctrl_tf_sw <= next_ctrl_tf_sw;
      reg_rdata <= next_reg_rdata;
    end
  end

  assign irq = |(evt & evt_en);

  AST_TF_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(stat_tf) |-> !$past(tf_inhibit)) // RL2
    else $error("terminal flag set while inhibited");
  AST_BCST_SILENT: assert property (@(posedge clk) disable iff (!rst_n)
    status_req |-> !bcast && (is_reserved(code) || !stat_bcst)) // RL3
    else $error("status sent for a broadcast");
  AST_ERR_SILENT: assert property (@(posedge clk) disable iff (!rst_n)
    seq_err |-> !status_req && stat_me) // RL4
    else $error("error sequence answered or without error bit");
  AST_RESERVED_ME: assert property (@(posedge clk) disable iff (!rst_n)
    status_req && is_reserved(code) |-> stat_me) // RL8
    else $error("reserved code answered without error bit");
  AST_VEC_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(vector_word_fetch_n) |-> $past(status_req)) // RL9
    else $error("vector fetch not right after status start");
  AST_VEC_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(vector_word_fetch_n) |-> tx_word_valid == 1'b0 ##1
      tx_word_valid && tx_word == $past(hw_s)) // RL10
    else $error("vector word not latched after fetch");
  AST_RST_AFTER_STATUS: assert property (@(posedge clk)
    disable iff (!rst_n)
    $fell(subsystem_reset_n_oe_n) |-> $past(status_req) || bcast) // RL6
    else $error("subsystem reset before status");
  AST_RST_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    term_reset |-> !tf_inhibit) // RL7
    else $error("terminal reset left inhibit set");
  AST_SYNC_HW: assert property (@(posedge clk) disable iff (!rst_n)
    !sync_word_strobe_n |-> !subsystem_highway_oe_n &&
      subsystem_highway_out == sync_word && $stable(sync_word)) // RL13
    else $error("highway not holding sync word during strobe");
  AST_TR_BAD: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_ok && in_group(cmd_mode_code) && tr_bad |=>
      stat_me && !status_req && stat_bcst == $past(cmd_bcast)) // RL15
    else $error("wrong direction bit not flagged");
endmodule // rtmc_handler

`default_nettype wire

// ### common/rtmc_map.svh
/*
  Constants of the remote terminal mode code handler: mode codes, register
  offsets, field positions, reset values and strobe timing.
  Assumes a 200 MHz core clock and a byte-addressed local register port.
*/
`ifndef RTMC_MAP_SVH
`define RTMC_MAP_SVH

// clock period and strobe timing, in ns
`define RTMC_CLK_NS 5
`define RTMC_STROBE_NS 500
`define RTMC_FETCH_NS 250
// least time to cycles, rounded up
`define RTMC_CYC(ns) (((ns) + `RTMC_CLK_NS - 1) / `RTMC_CLK_NS)

// mode codes handled here
`define RTMC_MC_OVR_TF 5'h07
`define RTMC_MC_RESET 5'h08
`define RTMC_MC_RSV_LO 5'h09
`define RTMC_MC_RSV_HI 5'h0F
`define RTMC_MC_VECTOR 5'h10
`define RTMC_MC_SYNC 5'h11

// register offsets (byte addresses)
`define RTMC_OFF_STAT 8'h00
`define RTMC_OFF_CTRL 8'h04
`define RTMC_OFF_EVT 8'h08
`define RTMC_OFF_EVT_CLR 8'h0C
`define RTMC_OFF_EVT_EN 8'h10
`define RTMC_OFF_VECTOR 8'h14
`define RTMC_OFF_SYNC 8'h18

// status register fields
`define RTMC_ST_ME 0
`define RTMC_ST_BCST 1
`define RTMC_ST_TF 2
`define RTMC_ST_INH 3
`define RTMC_ST_EXT_RST 4

// control register fields
`define RTMC_CTRL_TF_SW 0

// event bits
`define RTMC_EV_STATUS 0
`define RTMC_EV_MERR 1
`define RTMC_EV_RESET 2
`define RTMC_EV_SYNC 3
`define RTMC_EV_VECTOR 4
`define RTMC_EV_W 5

// reset values
`define RTMC_RST_EVT_EN 5'h00
`define RTMC_RST_CTRL 1'h0

`endif

// ### common/rtmc_pkg.sv
/*
  Types of the remote terminal mode code handler.
  Assumes the constants header is compiled alongside.
*/
package rtmc_pkg;

  // sequence state of one mode command
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_END,
    ST_WAIT_DATA
  } rtmc_state_t;

endpackage

// ### common/rtmc_pulse_if.sv
/*
  Interface between the handler and one timed strobe generator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface rtmc_pulse_if;
  logic start; // one-cycle request to begin a strobe
  logic active; // high for the whole strobe
  logic done; // one-cycle pulse after the strobe ends
  modport ctl (output start, input active, input done);
  modport gen (input start, output active, output done);
endinterface

`default_nettype wire

// ### core/rtmc_sync.sv
/*
  Two-stage synchroniser for a bus of asynchronous pin levels.
  Assumes the inputs need no common sampling between bits.
*/
`timescale 1ns/1ps
`default_nettype none

module rtmc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // first stage, read only by the second

  // register both stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // rtmc_sync

`default_nettype wire

// ### core/rtmc_pulse.sv
/*
  Timed strobe generator: active for exactly CYCLES clocks after start.
  Assumes start is ignored while a strobe runs.
*/
`timescale 1ns/1ps
`default_nettype none

module rtmc_pulse #(
  parameter int unsigned CYCLES = 100
) (
  input wire logic clk,
  input wire logic rst_n,
  rtmc_pulse_if.gen p
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("rtmc_pulse: CYCLES must be at least one");
  end

  logic [CW-1:0] cnt; // cycles left in the strobe
  logic [CW-1:0] next_cnt;
  logic done_q; // end-of-strobe pulse
  logic next_done;
  int unsigned width; // helper: length of the running strobe

  // count down while active, load on start
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_done = (cnt == CW'(1));
    end else if (p.start) begin
      next_cnt = CW'(CYCLES);
    end
  end

  // register counter and done pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      done_q <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done_q <= next_done;
    end
  end

  assign p.active = (cnt != '0);
  assign p.done = done_q;

  // helper: measure each strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      width <= 0;
    end else begin
      width <= p.active ? width + 1 : 0;
    end
  end

  AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(p.active) |-> (width == CYCLES) && p.done) // RL6
    else $error("strobe width differs from its set length");
endmodule // rtmc_pulse

`default_nettype wire

// ### bench/rtmc_subsys.sv
/*
  Subsystem model: answers vector fetches on the highway and resolves
  the shared highway and reset lines.
  Assumes one clock shared with the handler.
*/
`timescale 1ns/1ps
`default_nettype none

module rtmc_subsys (
  input wire logic clk,
  input wire logic slow,
  input wire logic [15:0] vec,
  input wire logic fetch_n,
  input wire logic [15:0] hw_out,
  input wire logic hw_oe_n,
  input wire logic rst_out,
  input wire logic rst_oe_n,
  output logic [15:0] hw_in,
  output logic rst_in
);
  logic [15:0] noise = 16'hA5A5; // undriven highway, changes every cycle
  logic late = 1'b0; // fetch strobe already seen one cycle
  // pattern generator and slow-answer delay
  always @(posedge clk) begin
    noise <= noise + 16'h3B5D;
    late <= !fetch_n;
  end
  // handler drive wins, vector only inside the fetch strobe
  always_comb begin
    if (!hw_oe_n) begin
      hw_in = hw_out;
    end else if (!fetch_n && (late || !slow)) begin
      hw_in = vec;
    end else begin
      hw_in = noise;
    end
  end
  // reset line has a pull-up
  assign rst_in = rst_oe_n ? 1'b1 : rst_out;
endmodule // rtmc_subsys

`default_nettype wire

// ### bench/test_rt_mode_code_handler_07_11.sv
/*
  Self-checking bench of the mode code handler against a model of flags,
  inhibit, strobe lengths and registers.
  Assumes the subsystem model on the same 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtmc_map.svh"

module test_rt_mode_code_handler_07_11;
  localparam int SC = 4; // shortened strobe length
  localparam int FC = 8; // shortened fetch length
  logic clk, rst_n, cmd_valid, cmd_ok, cmd_bcast, cmd_tr, word_valid;
  logic word_contig, msg_end, tf_inhibit_set, tf_request_pin, reg_wr, reg_rd;
  logic [4:0] cmd_mode_code;
  logic [15:0] word_data, subsystem_highway_in, vec, tx_word;
  logic [15:0] subsystem_highway_out;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, q;
  logic status_req, term_reset, tx_word_valid, subsystem_reset_n_in;
  logic subsystem_reset_n_out, subsystem_reset_n_oe_n, subsystem_highway_oe_n;
  logic vector_word_fetch_n, sync_word_strobe_n, irq, slow;
  logic [2:0] status_flags;
  logic m_me, m_bc, m_inh; // model: message error, broadcast, inhibit
  int n_errors = 0;
  int num_checks = 0;

  rtmc_handler #(.STROBE_CYC(SC), .FETCH_CYC(FC)) u_dut (
    .clk, .rst_n, .cmd_valid, .cmd_ok, .cmd_bcast, .cmd_tr, .cmd_mode_code,
    .word_valid, .word_contig, .word_data, .msg_end, .tf_inhibit_set,
    .tf_request_pin, .status_req, .status_flags, .term_reset, .tx_word,
    .tx_word_valid, .subsystem_reset_n_in, .subsystem_reset_n_out,
    .subsystem_reset_n_oe_n, .subsystem_highway_in, .subsystem_highway_out,
    .subsystem_highway_oe_n, .vector_word_fetch_n, .sync_word_strobe_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq
  );
  rtmc_subsys u_sub (
    .clk, .slow, .vec, .fetch_n(vector_word_fetch_n),
    .hw_out(subsystem_highway_out), .hw_oe_n(subsystem_highway_oe_n),
    .rst_out(subsystem_reset_n_out), .rst_oe_n(subsystem_reset_n_oe_n),
    .hw_in(subsystem_highway_in), .rst_in(subsystem_reset_n_in)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // verdict and end of run
  task automatic give_verdict();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // count a comparison, report a mismatch
  task automatic chk(input logic c, input string s);
    num_checks++;
    if (c !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, s);
    end
  endtask

  // one register access, read data taken the cycle after
  task automatic rg(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask

  // one command with words and end of message, then a fixed window
  task automatic cmd(input logic [4:0] c, input logic t, b, k,
                     input int nw, input logic ct);
    logic [15:0] w;
    logic err, ok, v, s, r;
    int nsr = 0, sr0 = 0, nfe = 0, fe0 = 99, nsn = 0, nok = 0;
    int nrs = 0, ntr = 0, ntx = 0;
    w = 16'($urandom);
    err = (c == 5'h11) ? (t || nw != 1 || !ct)
                       : (!t || nw != 0 || (b && c == 5'h10));
    ok = k && !err;
    v = ok && c == 5'h10;
    s = ok && c == 5'h11;
    r = ok && c == 5'h08;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_ok <= k;
    cmd_bcast <= b;
    cmd_tr <= t;
    cmd_mode_code <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (nw) begin
      word_valid <= 1'b1;
      word_contig <= ct;
      word_data <= w;
      @(posedge clk);
    end
    word_valid <= 1'b0;
    msg_end <= 1'b1;
    @(posedge clk);
    msg_end <= 1'b0;
    // model update: reserved codes keep old flags and add error
    if (k && t && c >= 5'h09 && c <= 5'h0F) begin
      m_me = 1'b1;
      m_bc = m_bc | b;
    end else if (k) begin
      m_me = err;
      m_bc = b;
    end
    if (ok && (c == 5'h07 || c == 5'h08)) m_inh = 1'b0;
    // observe the 40 cycles after the end of message
    for (int i = 0; i < 40; i++) begin
      #1;
      if (status_req === 1'b1) nsr++;
      if (status_req === 1'b1) sr0 = i;
      if (vector_word_fetch_n === 1'b0) nfe++;
      if (vector_word_fetch_n === 1'b0 && i < fe0) fe0 = i;
      if (sync_word_strobe_n === 1'b0) nsn++;
      if (sync_word_strobe_n === 1'b0 && subsystem_highway_oe_n === 1'b0
          && subsystem_highway_out === w) nok++;
      if (subsystem_reset_n_in === 1'b0) nrs++;
      if (term_reset === 1'b1) ntr++;
      if (tx_word_valid === 1'b1 && tx_word === vec) ntx++;
      @(posedge clk);
    end
    chk(nsr == ((ok && !b) ? 1 : 0), "status reply count");
    chk(nsr == 0 || sr0 == 0, "status timing");
    chk(status_flags === {tf_request_pin & ~m_inh, m_bc, m_me}, "flags");
    chk(nfe == (v ? FC : 0) && (!v || fe0 > sr0), "vector fetch");
    chk(ntx == (v ? 1 : 0), "vector word");
    chk(nsn == (s ? SC : 0) && nok == nsn, "sync strobe");
    chk(nrs == (r ? SC : 0), "reset strobe");
    chk(ntr == (r ? 1 : 0), "terminal reset");
  endtask

  // cut a hang short
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  // main sequence
  initial begin
    {rst_n, cmd_valid, cmd_ok, cmd_bcast, cmd_tr, word_valid} = '0;
    {word_contig, msg_end, tf_inhibit_set, tf_request_pin} = '0;
    {reg_wr, reg_rd, slow, m_me, m_bc, m_inh} = '0;
    {cmd_mode_code, word_data, reg_addr, reg_wdata, vec, q} = '0;
    void'($urandom(93));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(status_flags === 3'h0 && irq === 1'b0, "reset values");
    rg(1'b0, `RTMC_OFF_EVT_EN, 32'h0);
    chk(q === 32'h0, "enable reset value");
    rg(1'b1, `RTMC_OFF_EVT_EN, 32'h1);
    tf_request_pin <= 1'b1;
    vec <= 16'($urandom);
    cmd(5'h10, 1, 0, 1, 0, 1);
    chk(irq === 1'b1, "irq raised");
    rg(1'b0, `RTMC_OFF_VECTOR, 32'h0);
    chk(q === {16'h0000, vec}, "vector register");
    rg(1'b0, `RTMC_OFF_EVT, 32'h0);
    chk(q[0] === 1'b1, "status event");
    rg(1'b1, `RTMC_OFF_EVT_CLR, 32'h1F);
    rg(1'b0, `RTMC_OFF_EVT, 32'h0);
    chk(q === 32'h0 && irq === 1'b0, "event clear");
    rg(1'b1, `RTMC_OFF_EVT_EN, 32'h0);
    slow <= 1'b1;
    cmd(5'h10, 1, 0, 1, 0, 1);
    chk(irq === 1'b0, "irq masked");
    slow <= 1'b0;
    rg(1'b0, 8'h1C, 32'h0);
    chk(q === 32'h0, "unmapped read");
    cmd(5'h10, 1, 1, 1, 0, 1);
    cmd(5'h08, 1, 0, 1, 0, 1);
    cmd(5'h11, 0, 0, 1, 1, 1);
    cmd(5'h11, 0, 1, 1, 1, 1);
    cmd(5'h11, 1, 1, 1, 1, 1);
    cmd(5'h11, 0, 0, 1, 2, 1);
    cmd(5'h11, 0, 0, 1, 1, 0);
    cmd(5'h11, 0, 0, 1, 0, 1);
    cmd(5'h07, 1, 1, 1, 0, 1);
    cmd(5'h07, 1, 0, 1, 1, 1);
    cmd(5'h07, 1, 0, 0, 0, 1);
    for (int c = 7; c <= 16; c++) begin
      cmd(5'(c), 0, 1'(c % 2), 1, 0, 1);
      cmd(5'(c), 1, 0, 1, 0, 1);
    end
    rg(1'b0, `RTMC_OFF_STAT, 32'h0);
    chk(q[4:0] === {2'b00, 1'b1, m_bc, m_me}, "status register");
    // inhibit, then release by override and by terminal reset
    for (int j = 0; j < 2; j++) begin
      tf_inhibit_set <= 1'b1;
      m_inh = 1'b1;
      @(posedge clk);
      tf_inhibit_set <= 1'b0;
      cmd(5'h11, 0, 0, 1, 1, 1);
      cmd(j ? 5'h08 : 5'h07, 1, 0, 1, 0, 1);
    end
    give_verdict();
  end
endmodule // test_rt_mode_code_handler_07_11

`default_nettype wire
